//--- src/tcl_port_loopback.sv
// Purpose: per-port source and far-end loopback, serial line path and receive cell bus
// Assumes: transmit cell bits arrive from logic on pclk; line pins come from the framer
// Notes: pclk doubles as the processor clock that carries looped cells
module tcl_port_loopback (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phy_side_select_strap,
  input wire logic [7:0] serial_tx_clock,
  input wire logic [7:0] serial_rx_clock,
  input wire logic [7:0] serial_rx_frame_sync,
  input wire logic [7:0] serial_rx_data,
  output logic [7:0] serial_tx_data,
  input wire logic [7:0] tx_cell_bit,
  input wire logic [7:0] tx_cell_bit_valid,
  output logic standalone_mode,
  input wire logic rx_cell_bus_clock,
  input wire logic [4:0] rx_cell_bus_address,
  input wire logic rx_cell_enable_n,
  output logic [15:0] rx_cell_data_out,
  output logic rx_cell_parity_out,
  output logic rx_cell_available
);

  function automatic logic [7:0] rise8(input logic [7:0] prev, input logic [7:0] cur);
    rise8 = cur & ~prev;
  endfunction

  // ----------------------------------------------------------------
  // line pin synchronisers
  // ----------------------------------------------------------------
  tcl_pkg::tcl_line_pins_t pin_s1_q;
  tcl_pkg::tcl_line_pins_t pin_s2_q;
  logic [7:0] rx_clk_prev_q;
  logic [7:0] tx_clk_s1_q;
  logic [7:0] tx_clk_s2_q;
  logic [7:0] tx_clk_prev_q;
  logic [7:0] rx_rise;
  logic [7:0] tx_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      rx_clk_prev_q <= 8'h00;
      tx_clk_s1_q <= 8'h00;
      tx_clk_s2_q <= 8'h00;
      tx_clk_prev_q <= 8'h00;
    end else begin
      pin_s1_q <= {phy_side_select_strap, serial_rx_frame_sync, serial_rx_data, serial_rx_clock};
      pin_s2_q <= pin_s1_q;
      rx_clk_prev_q <= pin_s2_q.rx_clk;
      tx_clk_s1_q <= serial_tx_clock;
      tx_clk_s2_q <= tx_clk_s1_q;
      tx_clk_prev_q <= tx_clk_s2_q;
    end
  end

  // framer clocks are only seen as edges; a stopped clock stalls the port unless source loopback is on
  assign rx_rise = rise8(rx_clk_prev_q, pin_s2_q.rx_clk);
  assign tx_rise = rise8(tx_clk_prev_q, tx_clk_s2_q);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  tcl_pkg::tcl_port_mode_t mode_q [tcl_pkg::NUM_PORTS];
  tcl_pkg::tcl_cell_cfg_t cfg_q;
  logic standalone_q;
  logic [7:0] pending_q;
  logic [9:0] idx;
  logic mode_hit;
  logic [2:0] mode_port;
  logic known;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wr_en;
  tcl_pkg::tcl_status_t status;

  assign idx = paddr[11:2];
  assign mode_port = idx[7:5];
  assign mode_hit = (idx[4:0] == tcl_pkg::IDX_PORT_MODE[4:0]) && (idx[9:8] == 2'b00);
  assign known = mode_hit || (idx == tcl_pkg::IDX_CELL_CFG) || (idx == tcl_pkg::IDX_STATUS);
  assign wr_en = psel && penable && pready_q && pwrite && known;
  assign status = '{word_pending: pending_q, strap: pin_s2_q.strap, standalone: standalone_q};

  always_comb begin
    rd_d = 32'h0000_0000;
    if (mode_hit) begin
      rd_d[7:0] = mode_q[mode_port];
    end else if (idx == tcl_pkg::IDX_CELL_CFG) begin
      rd_d[7:0] = cfg_q;
    end else if (idx == tcl_pkg::IDX_STATUS) begin
      rd_d[9:0] = status;
    end
  end

  // no wait state: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !known;
      if (psel && !penable) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < tcl_pkg::NUM_PORTS; p++) begin
        mode_q[p] <= tcl_pkg::PORT_MODE_RST;
      end
      cfg_q <= tcl_pkg::CELL_CFG_RST;
    end else if (wr_en) begin
      if (mode_hit) begin
        mode_q[mode_port] <= {2'b00, pwdata[5:4], 4'h0};
      end else if (idx == tcl_pkg::IDX_CELL_CFG) begin
        cfg_q <= {pwdata[7:6], 5'h00, pwdata[0]};
      end
    end
  end

  // strap is caught through the synchroniser after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standalone_q <= 1'b0;
    end else begin
      standalone_q <= (cfg_q.mux == tcl_pkg::MUX_TC_DIRECT) && pin_s2_q.strap;
    end
  end

  // ----------------------------------------------------------------
  // per-port loopback selection and serial path
  // ----------------------------------------------------------------
  logic [7:0] src_on;
  logic [7:0] far_on;

  always_comb begin
    for (int p = 0; p < tcl_pkg::NUM_PORTS; p++) begin
      src_on[p] = mode_q[p].src_loop && standalone_q;
      far_on[p] = mode_q[p].far_loop && standalone_q && !mode_q[p].src_loop;
    end
  end

  logic [7:0] far_bit_q;
  logic [7:0] tx_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      far_bit_q <= 8'h00;
    end else begin
      for (int p = 0; p < tcl_pkg::NUM_PORTS; p++) begin
        if (rx_rise[p]) begin
          far_bit_q[p] <= pin_s2_q.rx_data[p];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= 8'hFF;
    end else begin
      for (int p = 0; p < tcl_pkg::NUM_PORTS; p++) begin
        if (src_on[p]) begin
          // processor-clocked bits against the line clock: garbage on the wire
          tx_q[p] <= tx_cell_bit[p];
        end else if (tx_rise[p]) begin
          if (far_on[p]) begin
            tx_q[p] <= far_bit_q[p];
          end else begin
            tx_q[p] <= tx_cell_bit_valid[p] ? tx_cell_bit[p] : 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive word assembly, one per port
  // ----------------------------------------------------------------
  logic [15:0] shift_q [tcl_pkg::NUM_PORTS];
  logic [4:0] cnt_q [tcl_pkg::NUM_PORTS];
  logic [15:0] hold_q [tcl_pkg::NUM_PORTS];
  logic [7:0] req_q;
  logic [7:0] ack_s1_q;
  logic [7:0] ack_s2_q;
  logic [7:0] ack_prev_q;
  logic [7:0] ack_rise;
  logic [7:0] ack_q;
  logic [4:0] word_bits;

  assign word_bits = cfg_q.wide ? tcl_pkg::WORD_BITS_WIDE : tcl_pkg::WORD_BITS_NARROW;
  assign ack_rise = ack_s2_q ^ ack_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1_q <= 8'h00;
      ack_s2_q <= 8'h00;
      ack_prev_q <= 8'h00;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      ack_prev_q <= ack_s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < tcl_pkg::NUM_PORTS; p++) begin
        shift_q[p] <= 16'h0000;
        cnt_q[p] <= 5'h00;
        hold_q[p] <= 16'h0000;
      end
      req_q <= 8'h00;
      pending_q <= 8'h00;
    end else begin
      for (int p = 0; p < tcl_pkg::NUM_PORTS; p++) begin
        logic take;
        logic bit_in;
        logic [15:0] word;
        take = 1'b0;
        bit_in = 1'b0;
        word = 16'h0000;
        if (src_on[p]) begin
          take = tx_cell_bit_valid[p];
          bit_in = tx_cell_bit[p];
        end else begin
          take = rx_rise[p];
          bit_in = pin_s2_q.rx_data[p];
        end
        if (ack_rise[p]) begin
          pending_q[p] <= 1'b0;
        end
        if (take) begin
          word = {shift_q[p][14:0], bit_in};
          shift_q[p] <= word;
          if (!src_on[p] && pin_s2_q.rx_sync[p]) begin
            cnt_q[p] <= 5'h01;
          end else if (cnt_q[p] + 5'h01 >= word_bits) begin
            cnt_q[p] <= 5'h00;
            // no buffering: a word arriving while the last is unread is lost
            if (!pending_q[p]) begin
              hold_q[p] <= word;
              req_q[p] <= !req_q[p];
              pending_q[p] <= 1'b1;
            end
          end else begin
            cnt_q[p] <= cnt_q[p] + 5'h01;
          end
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_tx_data = tx_q;
  assign standalone_mode = standalone_q;

  // ----------------------------------------------------------------
  // receive cell bus domain
  // ----------------------------------------------------------------
  logic rx_rst_s1_q;
  logic rx_rst_n_q;
  logic [7:0] req_s1_q;
  logic [7:0] req_s2_q;
  logic [7:0] req_prev_q;
  logic wide_s1_q;
  logic wide_s2_q;
  logic [7:0] avail_q;
  logic [15:0] word_q [tcl_pkg::NUM_PORTS];
  logic [15:0] data_q;
  logic parity_q;
  logic clav_q;
  logic [15:0] data_d;
  logic sel_ok;
  logic [2:0] sel;
  logic rd_hit;

  always_ff @(posedge rx_cell_bus_clock or negedge presetn) begin
    if (!presetn) begin
      rx_rst_s1_q <= 1'b0;
      rx_rst_n_q <= 1'b0;
    end else begin
      rx_rst_s1_q <= 1'b1;
      rx_rst_n_q <= rx_rst_s1_q;
    end
  end

  assign sel_ok = (rx_cell_bus_address < 5'h08);
  assign sel = rx_cell_bus_address[2:0];
  assign rd_hit = sel_ok && !rx_cell_enable_n && avail_q[sel];

  always_comb begin
    data_d = data_q;
    if (rd_hit) begin
      data_d = wide_s2_q ? word_q[sel] : {8'h00, word_q[sel][7:0]};
    end
  end

  always_ff @(posedge rx_cell_bus_clock or negedge rx_rst_n_q) begin
    if (!rx_rst_n_q) begin
      req_s1_q <= 8'h00;
      req_s2_q <= 8'h00;
      req_prev_q <= 8'h00;
      wide_s1_q <= 1'b0;
      wide_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_prev_q <= req_s2_q;
      wide_s1_q <= cfg_q.wide;
      wide_s2_q <= wide_s1_q;
    end
  end

  always_ff @(posedge rx_cell_bus_clock or negedge rx_rst_n_q) begin
    if (!rx_rst_n_q) begin
      avail_q <= 8'h00;
      ack_q <= 8'h00;
      for (int p = 0; p < tcl_pkg::NUM_PORTS; p++) begin
        word_q[p] <= 16'h0000;
      end
    end else begin
      for (int p = 0; p < tcl_pkg::NUM_PORTS; p++) begin
        if (rd_hit && sel == p[2:0]) begin
          avail_q[p] <= 1'b0;
          ack_q[p] <= !ack_q[p];
        end
        // hold word is stable until the acknowledge returns
        if (req_s2_q[p] != req_prev_q[p]) begin
          avail_q[p] <= 1'b1;
          word_q[p] <= hold_q[p];
        end
      end
    end
  end

  always_ff @(posedge rx_cell_bus_clock or negedge rx_rst_n_q) begin
    if (!rx_rst_n_q) begin
      data_q <= 16'h0000;
      parity_q <= 1'b1;
      clav_q <= 1'b0;
    end else begin
      data_q <= data_d;
      parity_q <= wide_s2_q ? ~^data_d : ~^data_d[7:0];
      clav_q <= sel_ok && avail_q[sel] && !rd_hit;
    end
  end

  assign rx_cell_data_out = data_q;
  assign rx_cell_parity_out = parity_q;
  assign rx_cell_available = clav_q;

endmodule

//--- src/tcl_pkg.sv
// Purpose: shared constants and carriers for the per-port loopback and receive cell-bus block
// Assumes: register byte address is four times the register index
// Notes: port mode registers repeat per port at a fixed index stride
package tcl_pkg;

  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_SYNC = 25;

  // register indices; byte address = index * 4
  localparam logic [9:0] IDX_PORT_MODE = 10'h004;
  localparam logic [9:0] IDX_PORT_STRIDE = 10'h020;
  localparam logic [9:0] IDX_CELL_CFG = 10'h202;
  localparam logic [9:0] IDX_STATUS = 10'h203;

  localparam logic [1:0] MUX_TC_DIRECT = 2'b10;
  localparam logic [7:0] PORT_MODE_RST = 8'h00;
  localparam logic [7:0] CELL_CFG_RST = 8'h00;

  localparam logic [4:0] WORD_BITS_NARROW = 5'h08;
  localparam logic [4:0] WORD_BITS_WIDE = 5'h10;

  // bit 5 source loopback, bit 4 far-end line loopback
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic src_loop;
    logic far_loop;
    logic [3:0] rsvd_lo;
  } tcl_port_mode_t;

  // bits 7:6 interface mux, bit 0 selects the 16-bit cell bus
  typedef struct packed {
    logic [1:0] mux;
    logic [4:0] rsvd;
    logic wide;
  } tcl_cell_cfg_t;

  typedef struct packed {
    logic [7:0] word_pending;
    logic strap;
    logic standalone;
  } tcl_status_t;

  typedef struct packed {
    logic strap;
    logic [7:0] rx_sync;
    logic [7:0] rx_data;
    logic [7:0] rx_clk;
  } tcl_line_pins_t;

endpackage

//--- testbench/tcl_port_loopback_monitor.sv
// Purpose: port-level checks on the loopback and receive cell-bus block
// Assumes: the config register changes only through bus writes
// Notes: bus-width mode is mirrored here from those writes
module tcl_port_loopback_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic phy_side_select_strap,
  input wire logic standalone_mode,
  input wire logic rx_cell_bus_clock,
  input wire logic [4:0] rx_cell_bus_address,
  input wire logic rx_cell_enable_n,
  input wire logic [15:0] rx_cell_data_out,
  input wire logic rx_cell_parity_out,
  input wire logic rx_cell_available
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // config mirror
  // ----
  logic [7:0] cfg_q;
  logic mapped;
  assign mapped = (paddr[11:10] == 2'b00 && paddr[6:2] == 5'h04) || paddr[11:2] == tcl_pkg::IDX_CELL_CFG
    || paddr[11:2] == tcl_pkg::IDX_STATUS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 8'h00;
    end else if (psel && penable && pready && pwrite && paddr[11:2] == tcl_pkg::IDX_CELL_CFG) begin
      cfg_q <= pwdata[7:0];
    end
  end
  // ----
  // checks
  // ----
  a_pready_once: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle after setup");
  a_slverr_map: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready && (pslverr != mapped)) else $error("error response wrong");
  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_standalone_on: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_q[7:6] == tcl_pkg::MUX_TC_DIRECT && phy_side_select_strap)[*8] |-> standalone_mode)
    else $error("standalone mode missing");
  a_standalone_off: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_q[7:6] != tcl_pkg::MUX_TC_DIRECT || !phy_side_select_strap)[*8] |-> !standalone_mode)
    else $error("standalone mode unexpected");
  a_parity_narrow: assert property (@(posedge rx_cell_bus_clock) disable iff (!presetn)
    !cfg_q[0] && !$past(cfg_q[0], 4) |-> rx_cell_parity_out == ~^rx_cell_data_out[7:0]
    && rx_cell_data_out[15:8] == 8'h00) else $error("narrow parity wrong");
  a_parity_wide: assert property (@(posedge rx_cell_bus_clock) disable iff (!presetn)
    cfg_q[0] && $past(cfg_q[0], 4) |-> rx_cell_parity_out == ~^rx_cell_data_out) else $error("wide parity wrong");
  a_avail_drop: assert property (@(posedge rx_cell_bus_clock) disable iff (!presetn)
    !rx_cell_enable_n && rx_cell_available && rx_cell_bus_address < 5'h08 |=> !rx_cell_available)
    else $error("available held after read");
  a_no_source: assert property (@(posedge rx_cell_bus_clock) disable iff (!presetn)
    (rx_cell_bus_address >= 5'h08)[*3] |-> !rx_cell_available) else $error("available on empty address");
endmodule

//--- testbench/tcl_atm_layer_model.sv
// Purpose: behavioural ATM-layer reader on the receive cell bus
// Assumes: one word is taken per read while the selected port offers one
// Notes: slow mode lets available stand a cycle before pulling enable
module tcl_atm_layer_model (
  input wire logic rx_cell_bus_clock,
  input wire logic presetn,
  input wire logic req,
  input wire logic slow,
  input wire logic [4:0] want,
  input wire logic rx_cell_available,
  output logic [4:0] rx_cell_bus_address,
  output logic rx_cell_enable_n,
  output logic [7:0] reads
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen_q;
  always_ff @(posedge rx_cell_bus_clock or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
      reads <= 8'h00;
      rx_cell_bus_address <= 5'h1f;
      rx_cell_enable_n <= 1'b1;
    end else begin
      seen_q <= rx_cell_available;
      rx_cell_bus_address <= want;
      // never two reads back to back: a fresh word needs a pclk round trip
      rx_cell_enable_n <= !(req && rx_cell_available && rx_cell_enable_n && rx_cell_bus_address == want
        && (!slow || seen_q));
      if (!rx_cell_enable_n && rx_cell_available) begin
        reads <= reads + 8'h01;
      end
    end
  end
endmodule

//--- testbench/tcl_port_loopback_tb_top.sv
// Purpose: self-checking bench for the loopback and receive cell-bus block
// Assumes: line clocks are slow against pclk so the synchronisers see every edge
// Notes: random words come from a fixed-seed shift register
module tcl_port_loopback_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, phy_side_select_strap, standalone_mode;
  logic rx_cell_bus_clock, rx_cell_enable_n, rx_cell_parity_out, rx_cell_available, req, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [7:0] serial_tx_clock, serial_rx_clock, serial_rx_frame_sync, serial_rx_data, serial_tx_data;
  logic [7:0] tx_cell_bit, tx_cell_bit_valid, reads;
  logic [4:0] rx_cell_bus_address, want;
  logic [15:0] rx_cell_data_out;
  int mismatches, total_checks, cycles;
  tcl_port_loopback dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .phy_side_select_strap, .serial_tx_clock, .serial_rx_clock, .serial_rx_frame_sync,
    .serial_rx_data, .serial_tx_data, .tx_cell_bit, .tx_cell_bit_valid, .standalone_mode, .rx_cell_bus_clock,
    .rx_cell_bus_address, .rx_cell_enable_n, .rx_cell_data_out, .rx_cell_parity_out, .rx_cell_available);
  tcl_atm_layer_model atm_u (.rx_cell_bus_clock, .presetn, .req, .slow, .want, .rx_cell_available,
    .rx_cell_bus_address, .rx_cell_enable_n, .reads);
  always #5 pclk = ~pclk;
  always #24 rx_cell_bus_clock = ~rx_cell_bus_clock;
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] pm_addr(input int p);
    return {tcl_pkg::IDX_PORT_MODE + tcl_pkg::IDX_PORT_STRIDE * 10'(p), 2'b00};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // pready is read at the edge itself, so it is the value that edge samples
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // framer side: clocks run only while bits are sent, line goes to inverse afterwards
  task automatic line_word(input int p, input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_rx_data[p] <= v[i];
      serial_rx_frame_sync[p] <= (i == n - 1);
      repeat (4) @(posedge pclk);
      serial_rx_clock[p] <= 1'b1;
      serial_tx_clock[p] <= 1'b1;
      repeat (4) @(posedge pclk);
      serial_rx_clock[p] <= 1'b0;
      serial_tx_clock[p] <= 1'b0;
    end
    serial_rx_frame_sync[p] <= 1'b0;
    serial_rx_data[p] <= ~v[0];
  endtask
  task automatic cell_word(input int p, input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      tx_cell_bit[p] <= v[i];
      tx_cell_bit_valid[p] <= 1'b1;
      @(posedge pclk);
      tx_cell_bit_valid[p] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task automatic read_word(input int p, input logic [15:0] exp);
    logic [7:0] r0;
    r0 = reads;
    want <= 5'(p);
    req <= 1'b1;
    while (reads === r0) begin
      @(posedge pclk);
    end
    req <= 1'b0;
    repeat (2) @(posedge rx_cell_bus_clock);
    @(posedge pclk);
    chk("rx cell data", 32'(exp), 32'(rx_cell_data_out));
    chk("rx cell parity", 32'(~^exp), 32'(rx_cell_parity_out));
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles >= 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {pclk, rx_cell_bus_clock, presetn, psel, penable, pwrite, phy_side_select_strap, req, slow} = 9'h000;
    {paddr, pwdata, seed, want} = {12'h000, 32'h0000_0000, 32'h0001_2d3e, 5'h1f};
    {serial_tx_clock, serial_rx_clock, serial_rx_frame_sync, serial_rx_data} = 32'h0000_0000;
    {tx_cell_bit, tx_cell_bit_valid} = 16'h0000;
    repeat (10) @(posedge pclk);
    chk("tx line in reset", 32'h0000_00ff, 32'(serial_tx_data));
    chk("parity in reset", 32'h0000_0001, 32'(rx_cell_parity_out));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      apb(pm_addr(p), 1'b0, 32'h0000_0000);
      chk("port mode reset", 32'h0000_0000, rd);
    end
    apb(12'h014, 1'b0, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, 32'(err));
    apb(12'h808, 1'b1, 32'h0000_0080);
    apb(pm_addr(3), 1'b1, 32'h0000_0010);
    apb(pm_addr(6), 1'b1, 32'hffff_ffef);
    apb(pm_addr(6), 1'b0, 32'h0000_0000);
    chk("port mode bits", 32'h0000_0020, rd);
    line_word(3, 16'h0000, 1);
    repeat (2) @(posedge pclk);
    chk("tx line strap low", 32'h0000_0001, 32'(serial_tx_data[3]));
    phy_side_select_strap <= 1'b1;
    // strap passes two synchroniser stages before the mode flag follows
    repeat (4) @(posedge pclk);
    apb(12'h80c, 1'b0, 32'h0000_0000);
    chk("status", 32'h0000_0003, rd & 32'h0000_0003);
    for (int b = 0; b < 3; b++) begin
      cell_word(3, 16'(~b[0]), 1);
      // a looped bit leaves on the line clock after the one that brought it in
      repeat (2) line_word(3, 16'(b[0]), 1);
      repeat (2) @(posedge pclk);
      chk("tx line far loop", 32'(b[0]), 32'(serial_tx_data[3]));
    end
    apb(pm_addr(2), 1'b1, 32'h0000_0020);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      slow <= k[0];
      line_word((k * 2 + 5) % 8, seed[15:0], 8);
      read_word((k * 2 + 5) % 8, {8'h00, seed[7:0]});
    end
    line_word(2, ~seed[15:0], 8);
    cell_word(2, seed[31:16], 8);
    read_word(2, {8'h00, seed[23:16]});
    line_word(1, ~seed[15:0], 8);
    want <= 5'h09;
    req <= 1'b1;
    repeat (6) @(posedge rx_cell_bus_clock);
    @(posedge pclk);
    chk("available empty address", 32'h0000_0000, 32'(rx_cell_available));
    read_word(1, {8'h00, ~seed[7:0]});
    seed = lfsr(seed);
    apb(12'h808, 1'b1, 32'h0000_0081);
    line_word(5, seed[15:0], 16);
    read_word(5, seed[15:0]);
    give_verdict();
  end
endmodule

bind tcl_port_loopback tcl_port_loopback_monitor mon_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .phy_side_select_strap, .standalone_mode, .rx_cell_bus_clock,
  .rx_cell_bus_address, .rx_cell_enable_n, .rx_cell_data_out, .rx_cell_parity_out, .rx_cell_available);
